// [include/tls_cfg.svh]
// Purpose: Offsets, field positions and reset values of the level subdivider
// Assumes: Levels are signed Q8.8 fixed point, registers one 32-bit word each
// Notes:   Definitions only
`ifndef TLS_CFG_SVH
`define TLS_CFG_SVH

// Number formats
`define TLS_LVL_W      16
`define TLS_FRAC_BITS  8
`define TLS_CNT_W      8
`define TLS_REL_W      9
`define TLS_REL_ONE    9'h100
`define TLS_LVL_ONE    16'sh0100
`define TLS_LVL_TWO    16'sh0200
`define TLS_NAN_CODE   16'h8000

// Register byte offsets
`define TLS_OFS_CTRL   8'h00
`define TLS_OFS_STAT   8'h04
`define TLS_OFS_MASK   8'h08
`define TLS_OFS_INFO   8'h0C
`define TLS_OFS_VAL0   8'h10
`define TLS_OFS_LOAD   8'h20
`define TLS_OFS_DCNT   8'h24

// Control fields
`define TLS_CTRL_EVAL  0
`define TLS_CTRL_DOM   1
`define TLS_CTRL_SP    3
`define TLS_CTRL_CW    5
`define TLS_CTRL_PT    6
`define TLS_CTRL_W     7
`define TLS_CTRL_RST   7'h00

// Status bits
`define TLS_ST_DISC    0
`define TLS_ST_BADSEL  1
`define TLS_ST_DONE    2
`define TLS_ST_W       3

// Default-level selectors
`define TLS_SEL_OUTER  32'h0000_0001
`define TLS_SEL_INNER  32'h0000_0002

`endif

// [include/tls_pkg.sv]
// Purpose: Types shared by the level subdivider modules
// Assumes: Encodings match the control register fields
// Notes:   Unused codes fall back to the defaults in the core
package tls_pkg;
  typedef enum logic [1:0] {
    TLS_DOM_TRI  = 2'h0,
    TLS_DOM_QUAD = 2'h1,
    TLS_DOM_LINE = 2'h2
  } tls_domain_t;

  typedef enum logic [1:0] {
    TLS_SP_EQUAL = 2'h0,
    TLS_SP_EVEN  = 2'h1,
    TLS_SP_ODD   = 2'h2
  } tls_spacing_t;

  typedef logic signed [15:0] tls_level_t;
endpackage

// [include/tls_edge_if.sv]
// Purpose: Carrier between the core and one edge-level unit
// Assumes: Purely combinational exchange
// Notes:   One instance per level
`timescale 1ns/10ps
`default_nettype none
`include "tls_cfg.svh"
interface tls_edge_if;
  import tls_pkg::*;
  tls_level_t                level;
  tls_spacing_t              spacing;
  logic [`TLS_CNT_W-1:0]     seg;
  logic [`TLS_REL_W-1:0]     frac;
  modport core      (output level, output spacing, input seg, input frac);
  modport edge_side (input level, input spacing, output seg, output frac);
endinterface
`default_nettype wire

// [hdl/tls_edge.sv]
// Purpose: Clamp and round one level into a segment count
// Assumes: Level in signed Q8.8; max level below 128
// Notes:   Pure combinational; the core registers the results
`timescale 1ns/10ps
`default_nettype none
`include "tls_cfg.svh"
module tls_edge import tls_pkg::*; #(
  parameter int unsigned MAX_SUBDIVISION_LEVEL = 64
) (
  tls_edge_if.edge_side e
);
  localparam tls_level_t MAX_Q = tls_level_t'(MAX_SUBDIVISION_LEVEL << `TLS_FRAC_BITS);

  logic             is_even;
  logic             is_odd;
  tls_level_t       lo_w;
  tls_level_t       hi_w;
  tls_level_t       fc_w;
  logic [7:0]       ceil_w;
  logic [7:0]       n_w;
  logic [16:0]      diff_w;

  // Clamp window per spacing; NaN code is the most negative value so it clamps low
  assign is_even = (e.spacing == TLS_SP_EVEN);
  assign is_odd  = (e.spacing == TLS_SP_ODD);
  assign lo_w    = is_even ? `TLS_LVL_TWO : `TLS_LVL_ONE;
  assign hi_w    = is_odd ? tls_level_t'(MAX_Q - `TLS_LVL_ONE) : MAX_Q;
  assign fc_w    = (e.level < lo_w) ? lo_w : ((e.level > hi_w) ? hi_w : e.level);

  // Round up, then to the parity the spacing asks for
  assign ceil_w = 8'(fc_w[15:8] + {7'h00, |fc_w[7:0]});
  assign n_w    = is_even ? 8'(ceil_w + {7'h00, ceil_w[0]}) :
                  is_odd  ? 8'(ceil_w + {7'h00, ~ceil_w[0]}) : ceil_w;

  // Extra segment length relative to the others: 1 - (n - f) / 2
  assign diff_w = {1'b0, n_w, 8'h00} - {1'b0, fc_w};
  assign e.seg  = n_w;
  assign e.frac = (!is_even && !is_odd) || (n_w == 8'h01) ? `TLS_REL_ONE :
                  9'(`TLS_REL_ONE - {1'b0, diff_w[8:1]});
endmodule
`default_nettype wire

// [hdl/tls_irq.sv]
// Purpose: Sticky event status, mask and one level interrupt
// Assumes: Status clears by writing ones
// Notes:   A set in the clearing cycle wins
`timescale 1ns/10ps
`default_nettype none
module tls_irq #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  input  wire logic         mask_we_i,
  input  wire logic [W-1:0] mask_d_i,
  output logic      [W-1:0] status_o,
  output logic      [W-1:0] mask_o,
  output logic              irq_o
);
  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  logic [W-1:0] mask_reg;

  // Set beats clear so no event is lost
  assign status_next = (status_reg & ~clr_i) | set_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg <= '0;
      mask_reg   <= '0;
    end else begin
      status_reg <= status_next;
      if (mask_we_i) begin
        mask_reg <= mask_d_i;
      end
    end
  end

  assign status_o = status_reg;
  assign mask_o   = mask_reg;
  assign irq_o    = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// [hdl/tls_top.sv]
// Purpose: Per-patch level selection, discard and edge segment counting
// Assumes: APB slave with zero wait states; levels are signed Q8.8
// Notes:   Mesh building is downstream; this stage hands over counts per patch
`timescale 1ns/10ps
`default_nettype none
`include "tls_cfg.svh"

// Notes on behaviour
// - Without evaluation stage, forward primitives unchanged
// - Triangle, quad and line-strip domains supported
// - Parameter outputs stay within unit range
// - Use stored defaults when patch lacks levels
// - Discard patch on non-positive or NaN outer
// - Relevant outers: quad four, tri three, line two
// - Negative inner levels never discard
// - Spacing equal, even or odd; equal default
// - Equal: clamp one..max, round up
// - Even: clamp two..max, round to even
// - Odd: clamp one..max-1, round to odd
// - Fractional: n-2 equal plus two extra segments
// - Extra length falls as n minus f grows
// - Extra placement depends only on clamped level
// - Winding configurable, counter-clockwise by default
// - Point output gives one point per vertex
// - Bad default selector rejected and flagged
// - Triangle ignores second inner and fourth outer
module tls_top import tls_pkg::*; #(
  parameter int unsigned MAX_SUBDIVISION_LEVEL = 64,
  parameter int unsigned DATA_W                = 32
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              patch_valid_i,
  output logic                   patch_ready_o,
  input  wire logic              patch_has_levels_i,
  input  wire logic [63:0]       patch_outer_i,
  input  wire logic [31:0]       patch_inner_i,
  input  wire logic [DATA_W-1:0] patch_data_i,
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic                   out_passthru_o,
  output logic [DATA_W-1:0]      out_data_o,
  output logic [1:0]             out_domain_o,
  output logic                   out_clockwise_winding_o,
  output logic                   out_point_mode_o,
  output logic [31:0]            out_outer_seg_o,
  output logic [15:0]            out_inner_seg_o,
  output logic [35:0]            out_outer_frac_o,
  output logic [17:0]            out_inner_frac_o,
  output logic                   irq_o
);
  localparam int NLVL = 6;

  logic [`TLS_CTRL_W-1:0]  ctrl_reg;
  tls_level_t              val_reg [4];
  tls_level_t              def_lvl_reg [NLVL];
  logic [15:0]             dcnt_reg;
  logic [31:0]             prdata_reg;
  logic                    out_valid_reg;
  logic                    out_pass_reg;
  logic [DATA_W-1:0]       out_data_reg;
  tls_domain_t             out_dom_reg;
  logic                    out_cw_reg;
  logic                    out_pt_reg;
  logic [`TLS_CNT_W-1:0]   seg_reg [NLVL];
  logic [`TLS_REL_W-1:0]   frac_reg [NLVL];
  logic                    out_valid_next;

  logic                    wr_w;
  logic                    rd_setup_w;
  logic                    hit_w;
  logic                    load_w;
  logic                    sel_outer_w;
  logic                    sel_inner_w;
  logic                    bad_sel_w;
  logic                    eval_w;
  logic [1:0]              dom_raw_w;
  logic [1:0]              sp_raw_w;
  tls_domain_t             dom_w;
  tls_spacing_t            spacing_w;
  tls_level_t              lvl_w [NLVL];
  logic [`TLS_CNT_W-1:0]   seg_w [NLVL];
  logic [`TLS_REL_W-1:0]   frac_w [NLVL];
  logic [3:0]              bad_outer_w;
  logic [3:0]              rel_mask_w;
  logic                    discard_w;
  logic                    acc_w;
  logic                    keep_w;
  logic                    done_w;
  logic [`TLS_ST_W-1:0]    st_w;
  logic [`TLS_ST_W-1:0]    mask_w;
  logic [`TLS_ST_W-1:0]    ev_w;
  logic [31:0]             rd_mux_w;

  // APB decode; no wait states so pready is constant
  assign wr_w       = psel_i && penable_i && pwrite_i;
  assign rd_setup_w = psel_i && !penable_i && !pwrite_i;
  assign hit_w      = (paddr_i == `TLS_OFS_CTRL) || (paddr_i == `TLS_OFS_STAT) ||
                      (paddr_i == `TLS_OFS_MASK) || (paddr_i == `TLS_OFS_INFO) ||
                      (paddr_i[7:4] == 4'h1 && paddr_i[1:0] == 2'h0) ||
                      (paddr_i == `TLS_OFS_LOAD) || (paddr_i == `TLS_OFS_DCNT);
  assign pready_o   = 1'b1;
  assign pslverr_o  = psel_i && penable_i && !hit_w;
  assign prdata_o   = prdata_reg;

  // Default-level load: only the two selectors are accepted
  assign load_w      = wr_w && (paddr_i == `TLS_OFS_LOAD);
  assign sel_outer_w = (pwdata_i == `TLS_SEL_OUTER);
  assign sel_inner_w = (pwdata_i == `TLS_SEL_INNER);
  assign bad_sel_w   = load_w && !sel_outer_w && !sel_inner_w;

  // Read mux; staging values sign-extend into the word
  assign rd_mux_w =
    (paddr_i == `TLS_OFS_CTRL) ? {25'h0, ctrl_reg} :
    (paddr_i == `TLS_OFS_STAT) ? {29'h0, st_w} :
    (paddr_i == `TLS_OFS_MASK) ? {29'h0, mask_w} :
    (paddr_i == `TLS_OFS_INFO) ? 32'(MAX_SUBDIVISION_LEVEL) :
    (paddr_i[7:4] == 4'h1)     ? {{16{val_reg[paddr_i[3:2]][15]}}, val_reg[paddr_i[3:2]]} :
    (paddr_i == `TLS_OFS_DCNT) ? {16'h0, dcnt_reg} : 32'h0000_0000;

  // Register writes in the access phase, read capture in the setup phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg   <= `TLS_CTRL_RST;
      prdata_reg <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        val_reg[i] <= `TLS_LVL_ONE;
      end
    end else begin
      if (rd_setup_w) begin
        prdata_reg <= hit_w ? rd_mux_w : 32'h0000_0000;
      end
      if (wr_w && paddr_i == `TLS_OFS_CTRL) begin
        ctrl_reg <= pwdata_i[`TLS_CTRL_W-1:0];
      end
      if (wr_w && paddr_i[7:4] == 4'h1 && paddr_i[1:0] == 2'h0) begin
        val_reg[paddr_i[3:2]] <= pwdata_i[15:0];
      end
    end
  end

  // Stored defaults: four outer, then two inner
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NLVL; i++) begin
        def_lvl_reg[i] <= `TLS_LVL_ONE;
      end
    end else if (load_w) begin
      for (int i = 0; i < 4; i++) begin
        if (sel_outer_w) begin
          def_lvl_reg[i] <= val_reg[i];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (sel_inner_w) begin
          def_lvl_reg[4+i] <= val_reg[i];
        end
      end
    end
  end

  // Mode decode; unused codes fall back to triangle and equal spacing
  assign eval_w    = ctrl_reg[`TLS_CTRL_EVAL];
  assign dom_raw_w = ctrl_reg[`TLS_CTRL_DOM +: 2];
  assign sp_raw_w  = ctrl_reg[`TLS_CTRL_SP +: 2];
  assign dom_w     = (dom_raw_w == TLS_DOM_QUAD) ? TLS_DOM_QUAD :
                     (dom_raw_w == TLS_DOM_LINE) ? TLS_DOM_LINE : TLS_DOM_TRI;
  assign spacing_w = (sp_raw_w == TLS_SP_EVEN) ? TLS_SP_EVEN :
                     (sp_raw_w == TLS_SP_ODD)  ? TLS_SP_ODD : TLS_SP_EQUAL;

  // One edge unit per level, fed from the patch or from the defaults
  tls_edge_if eif [NLVL] ();
  for (genvar g = 0; g < NLVL; g++) begin : g_edge
    if (g < 4) begin : g_outer
      assign lvl_w[g] = patch_has_levels_i ? patch_outer_i[g*16 +: 16] : def_lvl_reg[g];
      assign bad_outer_w[g] = (lvl_w[g] <= 16'sh0000);
    end else begin : g_inner
      assign lvl_w[g] = patch_has_levels_i ? patch_inner_i[(g-4)*16 +: 16] : def_lvl_reg[g];
    end
    assign eif[g].level   = lvl_w[g];
    assign eif[g].spacing = spacing_w;
    assign seg_w[g]       = eif[g].seg;
    assign frac_w[g]      = eif[g].frac;
    tls_edge #(
      .MAX_SUBDIVISION_LEVEL (MAX_SUBDIVISION_LEVEL)
    ) u_edge (
      .e (eif[g].edge_side)
    );
  end

  // Discard check over the relevant outers only; inner levels never count
  assign rel_mask_w = (dom_w == TLS_DOM_QUAD) ? 4'hF :
                      (dom_w == TLS_DOM_LINE) ? 4'h3 : 4'h7;
  assign discard_w  = |(bad_outer_w & rel_mask_w);

  // One output stage; ready looks through a draining output
  assign patch_ready_o  = !out_valid_reg || out_ready_i;
  assign acc_w          = patch_valid_i && patch_ready_o;
  assign keep_w         = acc_w && (!eval_w || !discard_w);
  assign done_w         = out_valid_reg && out_ready_i;
  assign out_valid_next = acc_w ? keep_w : (out_valid_reg && !out_ready_i);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_reg <= 1'b0;
      dcnt_reg      <= 16'h0000;
    end else begin
      out_valid_reg <= out_valid_next;
      if (acc_w && eval_w && discard_w) begin
        dcnt_reg <= 16'(dcnt_reg + 16'h0001);
      end
    end
  end

  // Captured patch; bypass carries data, domain and flags with zero counts
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_pass_reg <= 1'b0;
      out_data_reg <= '0;
      out_dom_reg  <= TLS_DOM_TRI;
      out_cw_reg   <= 1'b0;
      out_pt_reg   <= 1'b0;
    end else if (keep_w) begin
      out_pass_reg <= !eval_w;
      out_data_reg <= patch_data_i;
      out_dom_reg  <= dom_w;
      out_cw_reg   <= ctrl_reg[`TLS_CTRL_CW];
      out_pt_reg   <= ctrl_reg[`TLS_CTRL_PT];
    end
  end

  // Counts and fractions; triangle drops the fourth outer and second inner
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NLVL; i++) begin
        seg_reg[i]  <= '0;
        frac_reg[i] <= '0;
      end
    end else if (keep_w) begin
      for (int i = 0; i < NLVL; i++) begin
        if (!eval_w || (dom_w == TLS_DOM_TRI && (i == 3 || i == 5))) begin
          seg_reg[i]  <= '0;
          frac_reg[i] <= '0;
        end else begin
          seg_reg[i]  <= seg_w[i];
          frac_reg[i] <= frac_w[i];
        end
      end
    end
  end

  // Flatten for the plain port list
  for (genvar g = 0; g < 4; g++) begin : g_out_o
    assign out_outer_seg_o[g*8 +: 8]  = seg_reg[g];
    assign out_outer_frac_o[g*9 +: 9] = frac_reg[g];
  end
  for (genvar g = 0; g < 2; g++) begin : g_out_i
    assign out_inner_seg_o[g*8 +: 8]  = seg_reg[4+g];
    assign out_inner_frac_o[g*9 +: 9] = frac_reg[4+g];
  end
  assign out_valid_o             = out_valid_reg;
  assign out_passthru_o          = out_pass_reg;
  assign out_data_o              = out_data_reg;
  assign out_domain_o            = out_dom_reg;
  assign out_clockwise_winding_o = out_cw_reg;
  assign out_point_mode_o        = out_pt_reg;

  // Events into sticky status
  assign ev_w[`TLS_ST_DISC]   = acc_w && eval_w && discard_w;
  assign ev_w[`TLS_ST_BADSEL] = bad_sel_w;
  assign ev_w[`TLS_ST_DONE]   = done_w;

  tls_irq #(
    .W (`TLS_ST_W)
  ) u_irq (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .set_i     (ev_w),
    .clr_i     ((wr_w && paddr_i == `TLS_OFS_STAT) ? pwdata_i[`TLS_ST_W-1:0] : 3'h0),
    .mask_we_i (wr_w && paddr_i == `TLS_OFS_MASK),
    .mask_d_i  (pwdata_i[`TLS_ST_W-1:0]),
    .status_o  (st_w),
    .mask_o    (mask_w),
    .irq_o     (irq_o)
  );

  // Checks on the behaviour this stage guarantees
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_bypass_forward: assert property (acc_w && !eval_w |=> out_valid_reg && out_pass_reg
    && out_data_reg == $past(patch_data_i)) else $error("bypass did not forward");
  a_discard_drop: assert property (acc_w && eval_w && discard_w |=> !out_valid_reg
    && st_w[`TLS_ST_DISC]) else $error("discarded patch reached output");
  a_quad_fourth: assert property (acc_w && eval_w && dom_w == TLS_DOM_QUAD
    && lvl_w[3] <= 16'sh0000 |=> !out_valid_reg) else $error("quad fourth outer ignored");
  a_inner_no_drop: assert property (acc_w && eval_w && bad_outer_w == 4'h0
    |=> out_valid_reg) else $error("inner level caused discard");
  a_equal_range: assert property (out_valid_reg && !out_pass_reg && spacing_w == TLS_SP_EQUAL
    && $stable(ctrl_reg) && out_dom_reg == TLS_DOM_QUAD |-> seg_reg[0] >= 8'h01
    && seg_reg[0] <= 8'(MAX_SUBDIVISION_LEVEL)) else $error("equal count out of range");
  a_even_count: assert property (acc_w && eval_w && !discard_w && spacing_w == TLS_SP_EVEN
    |=> !seg_reg[0][0] && seg_reg[0] >= 8'h02) else $error("even count wrong");
  a_odd_count: assert property (acc_w && eval_w && !discard_w && spacing_w == TLS_SP_ODD
    |=> seg_reg[0][0] && seg_reg[0] < 8'(MAX_SUBDIVISION_LEVEL)) else $error("odd count wrong");
  a_frac_unit: assert property (out_valid_reg |-> frac_reg[0] <= `TLS_REL_ONE
    && frac_reg[4] <= `TLS_REL_ONE) else $error("fraction above one");
  a_tri_ignore: assert property (out_valid_reg && out_dom_reg == TLS_DOM_TRI
    |-> seg_reg[3] == 8'h00 && seg_reg[5] == 8'h00) else $error("triangle used ignored level");
  a_bad_select: assert property (bad_sel_w ##1 !(wr_w && paddr_i == `TLS_OFS_STAT)
    |-> st_w[`TLS_ST_BADSEL] && $stable(def_lvl_reg[0])) else $error("bad selector not flagged");
  a_hold_output: assert property (out_valid_reg && !out_ready_i |=> out_valid_reg
    && $stable(seg_reg[0])) else $error("output dropped under stall");

  // Counts and flags follow the patch that was taken; a bad selector leaves stored defaults alone
  a_discard_count: assert property (acc_w && eval_w && discard_w
    |=> dcnt_reg == 16'($past(dcnt_reg) + 16'h0001)) else $error("discard not counted");
  a_flags_follow: assert property (keep_w |=> out_cw_reg == $past(ctrl_reg[`TLS_CTRL_CW])
    && out_pt_reg == $past(ctrl_reg[`TLS_CTRL_PT])) else $error("flags not captured");
  a_equal_whole: assert property (keep_w && eval_w && spacing_w == TLS_SP_EQUAL
    |=> frac_reg[0] == `TLS_REL_ONE && frac_reg[4] == `TLS_REL_ONE) else $error("equal edge not whole");
  a_bad_keeps_inner: assert property (bad_sel_w |=> $stable(def_lvl_reg[4])
    && $stable(def_lvl_reg[5])) else $error("bad selector changed defaults");
  a_pass_zero: assert property (acc_w && !eval_w |=> seg_reg[0] == 8'h00
    && frac_reg[0] == 9'h000 && seg_reg[4] == 8'h00) else $error("bypass carried counts");

  c_discard: cover property (acc_w && eval_w && discard_w);
  c_bypass: cover property (acc_w && !eval_w);
  c_frac_odd: cover property (acc_w && eval_w && !discard_w && spacing_w == TLS_SP_ODD);
  c_default_load: cover property (load_w && sel_inner_w);
  c_stall_hold: cover property (out_valid_reg && !out_ready_i);
endmodule
`default_nettype wire

// [verif/tls_sink.sv]
// Purpose: Downstream evaluation stage model that accepts per-patch results
// Assumes: One result per handshake, fields packed by the bench
// Notes:   Slow mode stalls every other cycle so held outputs get exercised
`timescale 1ns/10ps
`default_nettype none
module tls_sink #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         valid_i,
  input  wire logic         slow_i,
  input  wire logic [W-1:0] data_i,
  output logic              ready_o,
  output logic [W-1:0]      cap_o,
  output logic [7:0]        got_o
);
  logic toggle_reg;

  // Ready drops every other cycle in slow mode, never kinder than a busy stage
  assign ready_o = !slow_i || toggle_reg;

  // Take one result per valid and ready edge, as the real stage would
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      toggle_reg <= 1'b0;
      cap_o      <= '0;
      got_o      <= 8'h00;
    end else begin
      toggle_reg <= !toggle_reg;
      if (valid_i && ready_o) begin
        cap_o <= data_i;
        got_o <= got_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tls_top_test.sv]
// Purpose: Self-checking bench for the level subdivider
// Assumes: Max level set to 16 so clamping is easy to reach
// Notes:   Results other than inner fractions are judged from what the downstream model accepted
`timescale 1ns/10ps
`default_nettype none
`include "tls_cfg.svh"
module tls_top_test;
  import tls_pkg::*;
  localparam int MAXL = 16;
  localparam logic [63:0] LVL_O = {16'h0100, 16'h6400, 16'h0080, 16'h0280};
  localparam logic [31:0] LVL_I = {16'h0300, 16'hFF00};
  localparam logic [31:0] OSEG [3] = '{{8'h01, 8'(MAXL), 8'h01, 8'h03}, {8'h02, 8'(MAXL), 8'h02, 8'h04},
                                     {8'h01, 8'(MAXL - 1), 8'h01, 8'h03}};
  localparam logic [15:0] ISEG [3] = '{16'h0301, 16'h0402, 16'h0301};
  localparam logic [35:0] OFRAC [3] = '{{4{9'h100}}, {27'h4020100, 9'h040}, {27'h4020100, 9'h0C0}};
  localparam logic [17:0] IFRAC [3] = '{{2{9'h100}}, {9'h080, 9'h100}, {2{9'h100}}};
  logic        clk_i = 0, reset_n_i = 0, psel = 0, pen = 0, pwr = 0, pv = 0, phl = 1, slow = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 0, pin = 0, pdata = 0, prdata, v;
  logic [63:0] pout = 0;
  logic        pready, perr, prdy, ov, ordy, opass, owind, opt, irq, took;
  logic [31:0] odata, oseg;
  logic [15:0] iseg;
  logic [35:0] ofrac;
  logic [17:0] ifrac;
  logic [1:0]  odom;
  logic [120:0] cap;
  logic [7:0]  got;
  int          bad_count = 0, checks = 0;

  always #5 clk_i = ~clk_i;

  tls_top #(.MAX_SUBDIVISION_LEVEL(MAXL)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .patch_valid_i(pv), .patch_ready_o(prdy), .patch_has_levels_i(phl), .patch_outer_i(pout),
    .patch_inner_i(pin), .patch_data_i(pdata), .out_valid_o(ov), .out_ready_i(ordy), .out_passthru_o(opass),
    .out_data_o(odata), .out_domain_o(odom), .out_clockwise_winding_o(owind), .out_point_mode_o(opt),
    .out_outer_seg_o(oseg), .out_inner_seg_o(iseg), .out_outer_frac_o(ofrac), .out_inner_frac_o(ifrac), .irq_o(irq));

  tls_sink #(.W(121)) sink (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(ov), .slow_i(slow),
    .data_i({opass, odata, odom, owind, opt, oseg, iseg, ofrac}), .ready_o(ordy), .cap_o(cap), .got_o(got));

  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    pen <= 1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    v = prdata;
    took = perr;
    psel <= 0; pen <= 0;
  endtask

  // Offer one patch, then wait a bounded time for the downstream model to take a result
  task run(input logic [63:0] o, input logic [31:0] i, input logic hl);
    logic [7:0] g0;
    int n;
    g0 = got;
    @(posedge clk_i);
    pv <= 1; pout <= o; pin <= i; phl <= hl; pdata <= pdata + 32'h11;
    @(posedge clk_i);
    while (prdy !== 1'b1) @(posedge clk_i);
    pv <= 0;
    n = 0;
    while (got === g0 && n < 8) begin @(posedge clk_i); n++; end
    took = (got !== g0);
  endtask

  task t_regs;
    apb(0, `TLS_OFS_CTRL, 0); chk("ctrl reset", v, 0);
    apb(0, `TLS_OFS_INFO, 0); chk("max level", v, MAXL);
    apb(0, 8'h30, 0); chk("unmapped err", took, 1);
  endtask

  task t_pass;
    run(LVL_O, LVL_I, 1); chk("pass taken", took, 1);
    chk("pass flag", cap[120], 1); chk("pass data", cap[119:88], pdata);
    chk("pass counts", cap[83:52], 0);
  endtask

  // All three spacings on one quad patch: clamp, rounding and extra length
  task t_spacing;
    for (int s = 0; s < 3; s++) begin
      apb(1, `TLS_OFS_CTRL, 32'h3 | (s << 3)); run(LVL_O, LVL_I, 1);
      chk("outer seg", cap[83:52], OSEG[s]);
      chk("inner seg", cap[51:36], ISEG[s]);
      chk("outer frac", cap[35:0], OFRAC[s]);
      chk("inner frac", ifrac, IFRAC[s]);
      chk("ccw default", cap[85], 0);
    end
  endtask

  task t_discard;
    apb(1, `TLS_OFS_MASK, 1); apb(1, `TLS_OFS_CTRL, 1);
    run({16'h0, {3{16'h0100}}}, 32'h0, 1); chk("tri kept", took, 1);
    chk("tri seg", cap[83:52], 32'h00010101);
    apb(1, `TLS_OFS_STAT, 7); run({16'h0100, 16'h0, 32'h01000100}, 0, 1); chk("tri drop", took, 0);
    @(negedge clk_i); chk("irq up", irq, 1);
    apb(1, `TLS_OFS_MASK, 0); @(negedge clk_i); chk("irq masked", irq, 0);
    apb(1, `TLS_OFS_MASK, 1); apb(1, `TLS_OFS_STAT, 1); @(negedge clk_i); chk("irq clr", irq, 0);
    apb(1, `TLS_OFS_CTRL, 5); run({32'h0, 32'h01000100}, 0, 1); chk("line kept", took, 1);
    run({32'h0, 32'h80000100}, 0, 1); chk("nan drop", took, 0);
    apb(1, `TLS_OFS_CTRL, 3); run({16'h0, {3{16'h0100}}}, 0, 1); chk("quad drop", took, 0);
    apb(0, `TLS_OFS_DCNT, 0); chk("discard count", v, 3);
  endtask

  task t_default;
    for (int k = 0; k < 4; k++) apb(1, `TLS_OFS_VAL0 + 8'(4 * k), 32'h200);
    apb(1, `TLS_OFS_LOAD, `TLS_SEL_OUTER);
    apb(1, `TLS_OFS_VAL0, 32'h300); apb(1, `TLS_OFS_VAL0 + 8'h04, 32'h300);
    apb(1, `TLS_OFS_LOAD, `TLS_SEL_INNER); apb(1, `TLS_OFS_LOAD, 32'h3);
    apb(0, `TLS_OFS_STAT, 0); chk("bad sel", v[1], 1);
    run(64'h0, 32'h0, 0); chk("def outer", cap[83:52], 32'h02020202);
    chk("def inner", cap[51:36], 16'h0303);
  endtask

  // Line domain with flags, two patches through a stalling downstream stage
  task t_flags;
    slow <= 1; apb(1, `TLS_OFS_CTRL, 32'h65);
    run(LVL_O, LVL_I, 1); run(LVL_O, LVL_I, 1); chk("stall taken", took, 1);
    chk("domain", cap[87:86], 2); chk("winding", cap[85], 1); chk("points", cap[84], 1);
    chk("line seg", cap[67:52], 16'h0103);
  endtask

  task complete_run;
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1;
    t_regs; t_pass; t_spacing; t_discard; t_default; t_flags;
    complete_run;
  end

  // Watchdog well beyond the couple of hundred cycles the scenarios need
  initial begin
    #200000;
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
